// >>> rtl/cal_lane_inverter.sv
`timescale 1ns/1ns
// per-lane optional inversion of the calibration pattern
module cal_lane_inverter #(
  parameter int LANES = 8
) (
  // pattern and invert mask
  input  wire logic             pattern_in,
  input  wire logic [LANES-1:0] invert_in,
  // lane values
  output logic      [LANES-1:0] lanes_out
);

  // elaboration check on lane count
  if (LANES < 1) begin : g_bad_lanes
    $error("cal_lane_inverter needs at least one lane");
  end

  // one xor per lane, each lane governed by its own mask bit
  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    assign lanes_out[lane] = pattern_in ^ invert_in[lane];
  end

endmodule : cal_lane_inverter

// >>> rtl/dq_cal_invert_and_vref_code.sv
`timescale 1ns/1ns
// Summary of operation
// (RULE1) eight-bit write-only invert mask, one bit per lane
// (RULE2) mask one inverts lane pattern, zero passes
// (RULE3) invert mask resets to hex 55
// (RULE4) mask/inversion lane always carries true pattern
// (RULE5) no bus inversion during calibration reads
// (RULE6) setting codes above 110010 reserved, never written
// (RULE7) range bit picks which reference range applies
// (RULE8) reference resets to range 1, code 011101
// (RULE9) separate reference copy per frequency set point
// (RULE10) write-select bit picks which copy is written
// (RULE11) operate-select copy drives device, other ignored
// (RULE12) reference read returns eight bits, reserved zero
// (RULE13) invert mask not readable, persists until rewritten
module dq_cal_invert_and_vref_code
  import dq_cal_vref_pkg::*;
#(
  parameter int LANES = CAL_LANES
) (
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 resetn_in,
  // mode-register commands
  input  wire logic                 mrw_valid_in,
  input  wire logic                 mrr_valid_in,
  input  wire logic [MR_ADDR_W-1:0] mr_addr_in,
  input  wire logic [OP_W-1:0]      mr_op_in,
  // set-point selects from the set-point control register
  input  wire logic                 set_point_write_select_in,
  input  wire logic                 set_point_operate_select_in,
  // bus inversion enable from the i/o configuration register
  input  wire logic                 dbi_enable_in,
  // calibration pattern stream
  input  wire logic                 cal_read_active_in,
  input  wire logic                 cal_pattern_bit_in,
  // mode-register read answer on dq 7..0
  output logic                      mrr_valid_out,
  output logic      [OP_W-1:0]      mrr_data_out,
  // calibration drive
  output logic                      cal_valid_out,
  output logic      [LANES-1:0]     cal_dq_out,
  output logic                      lower_mask_inversion_lane_out,
  // active reference level
  output logic      [CODE_W-1:0]    dq_reference_level_out,
  output logic                      dq_reference_range_select_out
);

  // elaboration check: the mask register is one operand wide
  if (LANES != OP_W) begin : g_bad_width
    $error("lane count must equal operand width");
  end

  // register state
  logic [SET_POINTS-1:0][REF_W-1:0] dq_ref_q, dq_ref_d;   // per set point copies
  logic [LANES-1:0]                 inv_q, inv_d;         // lower_byte_cal_invert
  // read answer state
  logic                             rd_valid_q, rd_valid_d;
  logic [OP_W-1:0]                  rd_data_q, rd_data_d;
  // calibration output state
  logic                             cal_valid_q, cal_valid_d;
  logic [LANES-1:0]                 cal_dq_q, cal_dq_d;
  logic                             mask_lane_q, mask_lane_d;
  // active reference state
  logic [REF_W-1:0]                 active_q, active_d;
  // decoded strobes and helpers
  logic                             ref_write;            // write to reference register
  logic                             ref_code_ok;          // code not reserved
  logic                             inv_write;            // write to invert register
  logic [REF_W-1:0]                 write_copy;           // copy chosen by write select
  logic [REF_W-1:0]                 operate_copy;         // copy chosen by operate select
  logic [LANES-1:0]                 lane_pattern;         // pattern after per-lane inversion

  // command decode
  assign ref_write    = mrw_valid_in && (mr_addr_in == DQ_REF_ADDR);
  assign inv_write    = mrw_valid_in && (mr_addr_in == CAL_INV_ADDR);
  assign ref_code_ok  = (mr_op_in[CODE_MSB:0] <= CODE_MAX);
  assign write_copy   = dq_ref_q[set_point_write_select_in];
  assign operate_copy = dq_ref_q[set_point_operate_select_in];

  // per-lane inversion of the pattern bit
  cal_lane_inverter #(
    .LANES (LANES)
  ) u_inverter (
    .pattern_in (cal_pattern_bit_in),
    .invert_in  (inv_q),
    .lanes_out  (lane_pattern)
  );

  // next values of the register file
  always_comb begin
    dq_ref_d = dq_ref_q;
    inv_d    = inv_q;
    // (RULE6) reserved codes dropped
    // (RULE10) write lands in selected copy
    if (ref_write && ref_code_ok) begin
      dq_ref_d[set_point_write_select_in] = mr_op_in[REF_W-1:0];
    end
    // (RULE1) whole mask written at once
    // (RULE13) held unless written
    if (inv_write) begin
      inv_d = mr_op_in[LANES-1:0];
    end
  end

  // register file flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // (RULE8) both copies reset to default
      // (RULE9) two copies kept
      dq_ref_q <= {SET_POINTS{DQ_REF_RESET}};
      // (RULE3) invert mask default
      inv_q    <= CAL_INV_RESET;
    end else begin
      dq_ref_q <= dq_ref_d;
      inv_q    <= inv_d;
    end
  end

  // next values of the read answer
  always_comb begin
    // (RULE12) reserved top bit reads zero
    rd_valid_d = mrr_valid_in && (mr_addr_in == DQ_REF_ADDR);
    rd_data_d  = rd_valid_d ? {1'b0, write_copy} : 8'h00;
  end

  // read answer flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
    end
  end

  // next values of the calibration drive
  always_comb begin
    cal_valid_d = cal_read_active_in;
    // (RULE2) inverted lanes from mask
    // (RULE5) bus inversion enable not consulted
    cal_dq_d    = cal_read_active_in ? lane_pattern : '0;
    // (RULE4) mask lane true pattern
    mask_lane_d = cal_read_active_in && cal_pattern_bit_in;
  end

  // calibration drive flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cal_valid_q <= 1'b0;
      cal_dq_q    <= '0;
      mask_lane_q <= 1'b0;
    end else begin
      cal_valid_q <= cal_valid_d;
      cal_dq_q    <= cal_dq_d;
      mask_lane_q <= mask_lane_d;
    end
  end

  // next active reference
  always_comb begin
    // (RULE11) operate copy only
    active_d = operate_copy;
  end

  // active reference flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_q <= DQ_REF_RESET;
    end else begin
      active_q <= active_d;
    end
  end

  // outputs
  assign mrr_valid_out                 = rd_valid_q;
  assign mrr_data_out                  = rd_data_q;
  assign cal_valid_out                 = cal_valid_q;
  assign cal_dq_out                    = cal_dq_q;
  assign lower_mask_inversion_lane_out = mask_lane_q;
  // (RULE7) range bit decoded apart from code
  assign dq_reference_level_out        = active_q[CODE_MSB:0];
  assign dq_reference_range_select_out = active_q[RANGE_BIT];

  // helper flags: registers untouched since reset
  logic inv_fresh_q;   // invert mask never written
  logic ref_fresh_q;   // reference never written
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      inv_fresh_q <= 1'b1;
      ref_fresh_q <= 1'b1;
    end else begin
      inv_fresh_q <= inv_fresh_q && !inv_write;
      ref_fresh_q <= ref_fresh_q && !(ref_write && ref_code_ok);
    end
  end

  // accepted reference writes per set point
  sequence s_ref_write0;
    ref_write && ref_code_ok && !set_point_write_select_in;
  endsequence
  sequence s_ref_write1;
    ref_write && ref_code_ok && set_point_write_select_in;
  endsequence

  a_inv_lanes: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE2
    cal_valid_out |-> cal_dq_out == ({LANES{$past(cal_pattern_bit_in)}} ^ $past(inv_q)))
    else $error("calibration lanes not inverted per mask");
  a_mask_true: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE4
    cal_valid_out |-> lower_mask_inversion_lane_out == $past(cal_pattern_bit_in))
    else $error("mask lane carried altered pattern");
  a_no_dbi_cal: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE5
    cal_read_active_in && dbi_enable_in
      |=> cal_dq_out == ({LANES{$past(cal_pattern_bit_in)}} ^ $past(inv_q)))
    else $error("bus inversion applied during calibration");
  a_inv_default: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE3
    inv_fresh_q |-> inv_q == CAL_INV_RESET)
    else $error("invert mask lost its reset value");
  a_ref_default: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE8
    ref_fresh_q |-> (dq_ref_q[0] == DQ_REF_RESET) && (dq_ref_q[1] == DQ_REF_RESET))
    else $error("reference copies lost reset value");
  a_reserved_kept: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE6
    ref_write && !ref_code_ok |=> dq_ref_q == $past(dq_ref_q))
    else $error("reserved code was stored");
  a_write_sp0: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE10
    s_ref_write0 |=> (dq_ref_q[0] == $past(mr_op_in[REF_W-1:0]))
                     && (dq_ref_q[1] == $past(dq_ref_q[1])))
    else $error("set point 0 write went astray");
  a_write_sp1: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE10
    s_ref_write1 |=> (dq_ref_q[1] == $past(mr_op_in[REF_W-1:0]))
                     && (dq_ref_q[0] == $past(dq_ref_q[0])))
    else $error("set point 1 write went astray");
  a_operate_copy: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE11
    ##1 {dq_reference_range_select_out, dq_reference_level_out} == $past(operate_copy))
    else $error("active reference not from operate copy");
  a_read_back: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE12
    mrr_valid_in && (mr_addr_in == DQ_REF_ADDR)
      |=> mrr_valid_out && (mrr_data_out == {1'b0, $past(write_copy)}))
    else $error("reference read answer wrong");
  a_inv_hold: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // RULE13
    !inv_write |=> inv_q == $past(inv_q))
    else $error("invert mask changed without a write");

endmodule : dq_cal_invert_and_vref_code

// >>> rtl/dq_cal_vref_pkg.sv
// shared constants for the reference-level and calibration-invert registers
package dq_cal_vref_pkg;

  // mode-register command fields
  localparam int MR_ADDR_W = 6;   // mode-register address width
  localparam int OP_W      = 8;   // operand width
  localparam int CODE_W    = 6;   // reference setting code width
  localparam int REF_W     = 7;   // stored bits: range select and code
  localparam int CAL_LANES = 8;   // lower-byte dq lanes

  // mode-register addresses served here
  localparam logic [MR_ADDR_W-1:0] DQ_REF_ADDR  = 6'h0E;
  localparam logic [MR_ADDR_W-1:0] CAL_INV_ADDR = 6'h0F;

  // field positions in the reference register
  localparam int CODE_MSB  = 5;   // top bit of the setting code
  localparam int RANGE_BIT = 6;   // range select bit

  // highest valid setting code; codes above it are reserved
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h32;

  // reset values
  localparam logic [OP_W-1:0]  CAL_INV_RESET = 8'h55;
  localparam logic [REF_W-1:0] DQ_REF_RESET  = 7'h5D;

  // number of frequency set points
  localparam int SET_POINTS = 2;

endpackage : dq_cal_vref_pkg

// >>> test/dq_cal_invert_and_vref_code_bench.sv
`timescale 1ns/1ns
// bench for the reference-level and calibration-invert registers
module dq_cal_invert_and_vref_code_bench
  import dq_cal_vref_pkg::*;
;
  logic                 core_clk_in;    // device clock
  logic                 resetn_in;      // active-low reset
  logic                 mrw_v, mrr_v;   // command strobes
  logic [MR_ADDR_W-1:0] addr;           // command address
  logic [OP_W-1:0]      op;             // write operand
  logic                 wsel, osel;     // set-point selects
  logic                 dbi, act, pat;  // bus inversion, stream
  logic                 rv, cv, mlane;  // answer flags
  logic [OP_W-1:0]      rd, cdq;        // answer data, lanes
  logic [5:0]           lvl;            // active code
  logic                 rng;            // active range
  int                   mismatches = 0; // failed compares
  int                   num_checks = 0; // all compares
  logic                 rv_s;           // captured answer flag
  logic [7:0]           rd_s;           // captured answer data

  dq_cal_invert_and_vref_code i_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .mrw_valid_in(mrw_v),
    .mrr_valid_in(mrr_v), .mr_addr_in(addr), .mr_op_in(op),
    .set_point_write_select_in(wsel), .set_point_operate_select_in(osel),
    .dbi_enable_in(dbi), .cal_read_active_in(act), .cal_pattern_bit_in(pat),
    .mrr_valid_out(rv), .mrr_data_out(rd), .cal_valid_out(cv), .cal_dq_out(cdq),
    .lower_mask_inversion_lane_out(mlane), .dq_reference_level_out(lvl),
    .dq_reference_range_select_out(rng));

  mr_controller_model ctl (
    .core_clk_in(core_clk_in), .mrr_valid_in(rv), .mrr_data_in(rd),
    .mrw_valid_out(mrw_v), .mrr_valid_out(mrr_v), .mr_addr_out(addr), .mr_op_out(op));

  // clock at 50 ns
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one calibration sample, answer one cycle later
  task automatic sample_cal(input logic b);
    @(negedge core_clk_in);
    act = 1'b1;
    pat = b;
    @(negedge core_clk_in);
    check("cal valid", {7'h0, cv}, 8'h01);
    act = 1'b0;
  endtask : sample_cal

  // reset values of level, read and mask
  task automatic test_reset();
    check("level", {2'h0, lvl}, 8'h1D);
    check("range", {7'h0, rng}, 8'h01);
    ctl.read_mr(DQ_REF_ADDR, rv_s, rd_s);
    check("ref read", rd_s, 8'h5D);
    check("ref valid", {7'h0, rv_s}, 8'h01);
    sample_cal(1'b1);
    check("cal lanes", cdq, 8'hAA);
    check("mask lane", {7'h0, mlane}, 8'h01);
    $display("test reset done");
  endtask : test_reset

  // new invert mask, bus inversion on, mask not readable
  task automatic test_invert();
    ctl.write_mr(CAL_INV_ADDR, 8'h15);
    dbi = 1'b1;
    sample_cal(1'b0);
    check("cal lanes", cdq, 8'h15);
    check("mask lane", {7'h0, mlane}, 8'h00);
    sample_cal(1'b1);
    check("cal lanes", cdq, 8'hEA);
    ctl.read_mr(CAL_INV_ADDR, rv_s, rd_s);
    check("mask read", {7'h0, rv_s}, 8'h00);
    check("mask data", rd_s, 8'h00);
    sample_cal(1'b0);
    check("mask kept", cdq, 8'h15);
    $display("test invert done");
  endtask : test_invert

  // writes to the idle set point, then switch to it
  task automatic test_set_points();
    @(negedge core_clk_in);
    wsel = 1'b1;
    ctl.write_mr(DQ_REF_ADDR, 8'hC5);
    ctl.read_mr(DQ_REF_ADDR, rv_s, rd_s);
    check("ref read", rd_s, 8'h45);
    ctl.write_mr(DQ_REF_ADDR, 8'h32);
    ctl.write_mr(DQ_REF_ADDR, 8'h73);
    ctl.read_mr(DQ_REF_ADDR, rv_s, rd_s);
    check("ref read", rd_s, 8'h32);
    check("level", {2'h0, lvl}, 8'h1D);
    wsel = 1'b0;
    ctl.read_mr(DQ_REF_ADDR, rv_s, rd_s);
    check("ref copy0", rd_s, 8'h5D);
    osel = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check("level", {2'h0, lvl}, 8'h32);
    check("range", {7'h0, rng}, 8'h00);
    $display("test set points done");
  endtask : test_set_points

  // reset in mid-run returns the written copy 1 and the mask to their defaults
  task automatic test_mid_reset();
    @(negedge core_clk_in);
    resetn_in = 1'b0;
    @(negedge core_clk_in);
    check("level", {2'h0, lvl}, 8'h1D);
    check("range", {7'h0, rng}, 8'h01);
    resetn_in = 1'b1;
    wsel      = 1'b1;
    ctl.read_mr(DQ_REF_ADDR, rv_s, rd_s);
    check("ref copy1", rd_s, 8'h5D);
    check("level", {2'h0, lvl}, 8'h1D);
    sample_cal(1'b1);
    check("cal lanes", cdq, 8'hAA);
    check("mask lane", {7'h0, mlane}, 8'h01);
    $display("test mid reset done");
  endtask : test_mid_reset

  // counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    resetn_in = 1'b0;
    {wsel, osel, dbi, act, pat} = 5'h00;
    repeat (2) @(negedge core_clk_in);
    resetn_in = 1'b1;
    test_reset();
    test_invert();
    test_set_points();
    test_mid_reset();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    #(2000 * 50);
    mismatches++;
    print_verdict();
  end
endmodule : dq_cal_invert_and_vref_code_bench

// >>> test/mr_controller_model.sv
`timescale 1ns/1ns
// controller side: issues mode-register writes and reads
module mr_controller_model
  import dq_cal_vref_pkg::*;
(
  // clock
  input  wire logic                 core_clk_in,
  // read answer from the device
  input  wire logic                 mrr_valid_in,
  input  wire logic [OP_W-1:0]      mrr_data_in,
  // command outputs
  output logic                      mrw_valid_out,
  output logic                      mrr_valid_out,
  output logic      [MR_ADDR_W-1:0] mr_addr_out,
  output logic      [OP_W-1:0]      mr_op_out
);
  // idle at time zero
  initial begin
    mrw_valid_out = 1'b0;
    mrr_valid_out = 1'b0;
    mr_addr_out   = 6'h00;
    mr_op_out     = 8'h00;
  end

  task automatic write_mr(input logic [MR_ADDR_W-1:0] addr, input logic [OP_W-1:0] op);
    @(negedge core_clk_in);
    mrw_valid_out = 1'b1;
    mr_addr_out   = addr;
    mr_op_out     = op;
    @(negedge core_clk_in);
    // released fields scrambled, never left showing
    mrw_valid_out = 1'b0;
    mr_addr_out   = ~addr;
    mr_op_out     = ~op;
  endtask : write_mr

  // read pulse; answer taken half a cycle after the taking edge
  task automatic read_mr(input logic [MR_ADDR_W-1:0] addr, output logic v,
                         output logic [OP_W-1:0] d);
    @(negedge core_clk_in);
    mrr_valid_out = 1'b1;
    mr_addr_out   = addr;
    @(negedge core_clk_in);
    v             = mrr_valid_in;
    d             = mrr_data_in;
    mrr_valid_out = 1'b0;
    mr_addr_out   = ~addr;
  endtask : read_mr
endmodule : mr_controller_model
